// *** tma_timer_a.sv ***
// Timer A mode register, clock output select and 8-bit counter with APB access
module tma_timer_a (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Sub clock input from pin
    input  wire logic        subClkIn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer outputs
    output logic             clkOut,
    output logic             overflow
);
    logic [7:0] timer_a_mode;
    logic [7:0] timer_a_count;
    logic       subSync1;
    logic       subSync2;
    logic       subSync3;
    logic       subTick;
    logic       sysTick;
    logic       holdReset;
    logic       cntTick;
    logic       outTick;
    logic [2:0] outSel;
    logic [3:0] srcSel;
    logic       apbWrite;
    logic       modeHit;
    logic       countHit;

    tma_prescaler_if sysPs ();
    tma_prescaler_if subPs ();

    // Sub clock crosses with two flops, third flop only for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            subSync1 <= 1'b0;
            subSync2 <= 1'b0;
            subSync3 <= 1'b0;
        end else begin
            subSync1 <= subClkIn;
            subSync2 <= subSync1;
            subSync3 <= subSync2;
        end
    end

    assign subTick = subSync2 && !subSync3;
    assign sysTick = 1'b1;

    assign outSel = timer_a_mode[7:tma_pkg::OUT_SEL_LSB];
    assign srcSel = timer_a_mode[3:0];
    assign holdReset = srcSel[tma_pkg::SRC_SEL_MSB] && srcSel[tma_pkg::SRC_SEL_LSB2];

    // System prescaler never stops; sub prescaler is held in the reset mode
    assign sysPs.clear = 1'b0;
    assign subPs.clear = holdReset;

    tma_prescaler #(.WIDTH(tma_pkg::SYS_PS_WIDTH)) u_sysPs (
        .clk     (clk),
        .rst_n   (rst_n),
        .countEn (sysTick),
        .ps      (sysPs)
    );

    tma_prescaler #(.WIDTH(tma_pkg::SUB_PS_WIDTH)) u_subPs (
        .clk     (clk),
        .rst_n   (rst_n),
        .countEn (subTick),
        .ps      (subPs)
    );

    // Output clock select: system or sub clock over 32, 16, 8, 4
    always_comb begin
        case (outSel)
            3'h0:    outTick = sysPs.taps[3];
            3'h1:    outTick = sysPs.taps[2];
            3'h2:    outTick = sysPs.taps[1];
            3'h3:    outTick = sysPs.taps[0];
            3'h4:    outTick = subPs.taps[3];
            3'h5:    outTick = subPs.taps[2];
            3'h6:    outTick = subPs.taps[1];
            3'h7:    outTick = subPs.taps[0];
            default: outTick = 1'b0;
        endcase
    end

    // Square output toggles on each half period tick, giving the selected divisor
    logic outTickHalf;
    always_comb begin
        case (outSel)
            3'h0:    outTickHalf = sysPs.taps[3];
            default: outTickHalf = outTick;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkOut <= 1'b0;
        end else if (outTickHalf) begin
            clkOut <= !clkOut;
        end
    end

    // Counter clock select
    always_comb begin
        cntTick = 1'b0;
        if (!srcSel[tma_pkg::SRC_SEL_MSB]) begin
            case (srcSel[2:0])
                3'h0:    cntTick = sysPs.taps[12];
                3'h1:    cntTick = sysPs.taps[11];
                3'h2:    cntTick = sysPs.taps[10];
                3'h3:    cntTick = sysPs.taps[8];
                3'h4:    cntTick = sysPs.taps[7];
                3'h5:    cntTick = sysPs.taps[6];
                3'h6:    cntTick = sysPs.taps[4];
                3'h7:    cntTick = sysPs.taps[2];
                default: cntTick = 1'b0;
            endcase
        end else if (!srcSel[tma_pkg::SRC_SEL_LSB2]) begin
            case (srcSel[1:0])
                2'h0:    cntTick = subPs.taps[tma_pkg::TB_TAP0];
                2'h1:    cntTick = subPs.taps[tma_pkg::TB_TAP1];
                2'h2:    cntTick = subPs.taps[tma_pkg::TB_TAP2];
                2'h3:    cntTick = subPs.taps[tma_pkg::TB_TAP3];
                default: cntTick = 1'b0;
            endcase
        end
    end

    // Counter with wrap; overflow is a one-cycle pulse on wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_a_count <= 8'h00;
            overflow      <= 1'b0;
        end else if (holdReset) begin
            timer_a_count <= 8'h00;
            overflow      <= 1'b0;
        end else begin
            overflow <= cntTick && (timer_a_count == 8'hff);
            if (cntTick) begin
                timer_a_count <= timer_a_count + 8'h01;
            end
        end
    end

    // APB slave, zero wait states
    assign pready   = 1'b1;
    assign modeHit  = (paddr == tma_pkg::MODE_ADDR);
    assign countHit = (paddr == tma_pkg::COUNT_ADDR);
    assign apbWrite = psel && penable && pwrite;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_a_mode <= tma_pkg::MODE_RESET;
        end else if (apbWrite && modeHit && pstrb[0]) begin
            timer_a_mode <= (pwdata[7:0] & tma_pkg::MODE_WMASK)
                          | (~tma_pkg::MODE_WMASK);
        end
    end

    // Write to the read-only counter or any access to an unmapped address reports an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = !(modeHit || (countHit && !pwrite));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (modeHit) begin
                prdata <= {24'h00_0000, timer_a_mode};
            end else if (countHit) begin
                prdata <= {24'h00_0000, timer_a_count};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Assertions
    property p_mode_bit4;
        @(posedge clk) disable iff (!rst_n) timer_a_mode[4] == 1'b1;
    endproperty
    a_mode_bit4: assert property (p_mode_bit4) else $error("Mode bit 4 not one");

    property p_hold;
        @(posedge clk) disable iff (!rst_n) holdReset |=> (timer_a_count == 8'h00);
    endproperty
    a_hold: assert property (p_hold) else $error("Counter not held in reset mode");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
            (cntTick && !holdReset && timer_a_count == 8'hff)
            |=> (timer_a_count == 8'h00) && overflow;
    endproperty
    a_wrap: assert property (p_wrap) else $error("Counter did not wrap");

    property p_inc;
        @(posedge clk) disable iff (!rst_n)
            (cntTick && !holdReset) |=> timer_a_count == $past(timer_a_count) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("Counter did not increment");

    property p_interval8;
        @(posedge clk) disable iff (!rst_n) (srcSel == 4'h7 && cntTick) |=> !cntTick [*3];
    endproperty
    a_interval8: assert property (p_interval8) else $error("Fastest interval spacing wrong");

    property p_tb_sub;
        @(posedge clk) disable iff (!rst_n) (srcSel[3:2] == 2'b10 && cntTick) |-> subTick;
    endproperty
    a_tb_sub: assert property (p_tb_sub) else $error("Time base not from sub clock");

    property p_out4;
        @(posedge clk) disable iff (!rst_n)
            (outSel == 3'h3 && !$changed(outSel) && outTick && !(apbWrite && modeHit))
            |=> !outTick [*1] ##1 outTick;
    endproperty
    a_out4: assert property (p_out4) else $error("System over 4 output tick spacing wrong");

    property p_sub_hold;
        @(posedge clk) disable iff (!rst_n) holdReset |-> subPs.taps == 15'h0000;
    endproperty
    a_sub_hold: assert property (p_sub_hold) else $error("Sub prescaler ran in reset mode");

    // Write byte kept as its own signal so its past value can be sampled
    logic [7:0] wrByte;
    assign wrByte = pwdata[7:0];

    property p_mode_wr;
        @(posedge clk) disable iff (!rst_n) (apbWrite && modeHit && pstrb[0])
            |=> timer_a_mode == ($past(wrByte) | ~tma_pkg::MODE_WMASK);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("Mode write not taken");

    property p_mode_keep;
        @(posedge clk) disable iff (!rst_n) !(apbWrite && modeHit && pstrb[0])
            |=> $stable(timer_a_mode);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("Mode changed without write");

    property p_rd_bit4;
        @(posedge clk) disable iff (!rst_n) (psel && !penable && !pwrite && modeHit)
            |=> prdata[4] == 1'b1;
    endproperty
    a_rd_bit4: assert property (p_rd_bit4) else $error("Mode read bit 4 not one");

    property p_rd_upper;
        @(posedge clk) disable iff (!rst_n) prdata[31:8] == 24'h00_0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("Read data upper bits set");

    property p_ovf_pulse;
        @(posedge clk) disable iff (!rst_n) overflow |=> !overflow;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("Overflow longer than one cycle");

    property p_ovf_zero;
        @(posedge clk) disable iff (!rst_n) overflow |-> timer_a_count == 8'h00;
    endproperty
    a_ovf_zero: assert property (p_ovf_zero) else $error("Overflow without wrap to zero");

    property p_hold_ovf;
        @(posedge clk) disable iff (!rst_n) holdReset |=> !overflow;
    endproperty
    a_hold_ovf: assert property (p_hold_ovf) else $error("Overflow in reset mode");

    property p_hold_tick;
        @(posedge clk) disable iff (!rst_n) holdReset |-> !cntTick;
    endproperty
    a_hold_tick: assert property (p_hold_tick) else $error("Counter ticked in reset mode");

    // Mode write edge is skipped: a slower selection may tick just after it
    property p_tb_fast;
        @(posedge clk) disable iff (!rst_n)
            (srcSel == 4'hb && cntTick && !(apbWrite && modeHit)) |=> !cntTick [*7];
    endproperty
    a_tb_fast: assert property (p_tb_fast) else $error("Fastest time base spacing wrong");

    property p_sub_idle;
        @(posedge clk) disable iff (!rst_n) !subTick |-> subPs.taps == 15'h0000;
    endproperty
    a_sub_idle: assert property (p_sub_idle) else $error("Sub tap without sub edge");

    property p_int_tap;
        @(posedge clk) disable iff (!rst_n) (!srcSel[3] && cntTick) |-> sysPs.taps[2];
    endproperty
    a_int_tap: assert property (p_int_tap) else $error("Interval tick off system taps");

    property p_clk_toggle;
        @(posedge clk) disable iff (!rst_n) outTick |=> clkOut != $past(clkOut);
    endproperty
    a_clk_toggle: assert property (p_clk_toggle) else $error("Output clock missed a toggle");

    property p_clk_keep;
        @(posedge clk) disable iff (!rst_n) !outTick |=> $stable(clkOut);
    endproperty
    a_clk_keep: assert property (p_clk_keep) else $error("Output clock toggled early");

    property p_sub_out4;
        @(posedge clk) disable iff (!rst_n)
            (outSel == 3'h7 && outTick && !(apbWrite && modeHit)) |=> !outTick [*3];
    endproperty
    a_sub_out4: assert property (p_sub_out4) else $error("Sub over 4 tick spacing wrong");
endmodule : tma_timer_a

// *** tma_pkg.sv ***
// Package of register map, field positions and divider constants for the timer A mode block
package tma_pkg;
    // Register indices: the bus byte address is four times the index
    localparam logic [7:0]  MODE_OFFSET     = 8'hb0;
    localparam logic [7:0]  COUNT_OFFSET    = 8'hb1;
    localparam logic [9:0]  MODE_ADDR       = {MODE_OFFSET, 2'b00};
    localparam logic [9:0]  COUNT_ADDR      = {COUNT_OFFSET, 2'b00};
    localparam logic [7:0]  MODE_RESET      = 8'h10;
    localparam logic [7:0]  MODE_WMASK      = 8'hef;
    localparam int          OUT_SEL_LSB     = 5;
    localparam int          SRC_SEL_MSB     = 3;
    localparam int          SRC_SEL_LSB2    = 2;
    localparam int          SYS_PS_WIDTH    = 13;
    localparam int          SUB_PS_WIDTH    = 15;
    // Time-base periods in ms with a 32.768 kHz sub clock
    localparam int          TB_PERIOD_MS0   = 1000;
    localparam int          SUB_CLK_HZ      = 32768;
    // Sub prescaler tap indices reaching 1 s, 0.5 s, 0.25 s, 0.03125 s over 256 counts
    localparam int          TB_TAP0         = 6;
    localparam int          TB_TAP1         = 5;
    localparam int          TB_TAP2         = 4;
    localparam int          TB_TAP3         = 1;
endpackage : tma_pkg

// *** tma_prescaler_if.sv ***
// Interface carrying prescaler taps between the divider and the timer core
interface tma_prescaler_if;
    logic        clear;
    logic [14:0] taps;
    modport div (input clear, output taps);
    modport core (output clear, input taps);
endinterface : tma_prescaler_if

// *** tma_prescaler.sv ***
// Prescaler with synchronous clear producing one-cycle tick taps from a clock enable
module tma_prescaler #(
    parameter int WIDTH = 15
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Count enable
    input  wire logic       countEn,
    // Tap outputs
    tma_prescaler_if.div    ps
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (ps.clear) begin
            count <= '0;
        end else if (countEn) begin
            count <= next_count;
        end
    end

    // Tap k pulses when bits k..0 of the next count are all zero, every 2^(k+1) enables
    always_comb begin
        ps.taps = '0;
        for (int k = 0; k < WIDTH && k < 15; k++) begin
            ps.taps[k] = countEn && !ps.clear && ((next_count << (WIDTH - 1 - k)) == '0);
        end
    end
endmodule : tma_prescaler

// *** tb_tma_timer_a.sv ***
// Self-checking testbench for the timer A mode block
module tb_tma_timer_a;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        rst_n;
    logic        subClkIn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clkOut;
    logic        overflow;
    int          nFail;
    int          checkCount;

    tma_timer_a i_tma_timer_a (
        .clk(clk), .rst_n(rst_n), .subClkIn(subClkIn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clkOut(clkOut), .overflow(overflow)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Sub clock at half the system rate keeps the long time-base periods short
    always @(posedge clk) begin
        subClkIn <= ~subClkIn;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; read data and error are judged at the completing edge
    task automatic xfer(input logic wr, input logic [9:0] addr, input logic [31:0] wdata,
                        input logic [31:0] expData, input logic expErr);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            nFail++;
            report_and_stop();
        end
        if (!wr) begin
            chk(prdata, expData);
        end
        chk({31'h0, pslverr}, {31'h0, expErr});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // Cycles between two rises of clkOut or two overflow pulses
    task automatic period(input logic useClk, input logic [31:0] exp);
        logic        prev;
        logic        cur;
        logic        seen;
        logic [31:0] cyc;
        prev = 1'b1;
        seen = 1'b0;
        cyc  = 32'h0;
        for (int n = 0; n < 40000; n++) begin
            @(posedge clk);
            cyc++;
            cur = useClk ? clkOut : overflow;
            if (cur === 1'b1 && prev === 1'b0) begin
                if (seen) begin
                    chk(cyc, exp);
                    return;
                end
                seen = 1'b1;
                cyc  = 32'h0;
            end
            prev = cur;
        end
        nFail++;
        report_and_stop();
    endtask : period

    task automatic reg_access;
        xfer(1'b0, tma_pkg::MODE_ADDR, 32'h0, 32'h10, 1'b0);
        xfer(1'b1, tma_pkg::MODE_ADDR, 32'hff, 32'h0, 1'b0);
        xfer(1'b0, tma_pkg::MODE_ADDR, 32'h0, 32'hff, 1'b0);
        xfer(1'b1, tma_pkg::MODE_ADDR, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, tma_pkg::MODE_ADDR, 32'h0, 32'h10, 1'b0);
        // Low byte lane off: the write must leave the mode alone
        pstrb <= 4'he;
        xfer(1'b1, tma_pkg::MODE_ADDR, 32'hff, 32'h0, 1'b0);
        pstrb <= 4'hf;
        xfer(1'b0, tma_pkg::MODE_ADDR, 32'h0, 32'h10, 1'b0);
        xfer(1'b1, tma_pkg::COUNT_ADDR, 32'h55, 32'h0, 1'b1);
        xfer(1'b0, tma_pkg::COUNT_ADDR, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, 10'h2d0, 32'h0, 32'h0, 1'b1);
    endtask : reg_access

    // Counter runs fast first so that the hold has something to clear
    task automatic hold_reset;
        xfer(1'b1, tma_pkg::MODE_ADDR, 32'h07, 32'h0, 1'b0);
        repeat (100) @(posedge clk);
        xfer(1'b1, tma_pkg::MODE_ADDR, 32'h0d, 32'h0, 1'b0);
        repeat (40) @(posedge clk);
        xfer(1'b0, tma_pkg::COUNT_ADDR, 32'h0, 32'h0, 1'b0);
        repeat (40) @(posedge clk);
        xfer(1'b0, tma_pkg::COUNT_ADDR, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, tma_pkg::MODE_ADDR, 32'h0, 32'h1d, 1'b0);
    endtask : hold_reset

    // Mode value, then clkOut period alone in system cycles
    task automatic out_run(input logic [7:0] mode, input logic [31:0] clkP);
        xfer(1'b1, tma_pkg::MODE_ADDR, {24'h0, mode}, 32'h0, 1'b0);
        period(1'b1, clkP);
    endtask : out_run

    // Mode value, then clkOut period and overflow period in system cycles
    task automatic mode_run(input logic [7:0] mode, input logic [31:0] clkP,
                            input logic [31:0] ovfP);
        xfer(1'b1, tma_pkg::MODE_ADDR, {24'h0, mode}, 32'h0, 1'b0);
        period(1'b1, clkP);
        period(1'b0, ovfP);
    endtask : mode_run

    initial begin
        nFail      = 0;
        checkCount = 0;
        rst_n      = 1'b0;
        subClkIn   = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 10'h000;
        pwdata     = 32'h0;
        pstrb      = 4'hf;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_access();
        hold_reset();
        out_run(8'h27, 32'h10);
        out_run(8'h47, 32'h8);
        out_run(8'he7, 32'h8);
        out_run(8'ha7, 32'h20);
        mode_run(8'h67, 32'h4, 32'h800);
        mode_run(8'hc6, 32'h10, 32'h2000);
        mode_run(8'h8b, 32'h40, 32'h800);
        mode_run(8'h0a, 32'h20, 32'h4000);
        report_and_stop();
    end
endmodule : tb_tma_timer_a
